//--- boundary_scan_test_port.sv
// Boundary-scan test port with pad muxing
`timescale 1ns/1ps

// Functional notes
// - Every bus pad and serial ROM pad has a boundary-scan cell.
// - Dedicated chain cells hold the output enables of two-way pad groups.
// - In external test, an enable cell at 1 drives its pads from cells.
// - Chain starts at interrupt, reset, clock, grant, request, then bus groups.
// - Chain ends with serial ROM, internal cells, boot ROM address bits.
// - Eleven internal cells have no pad but shift like pad cells.
// - Controller follows mode select sequences sampled on the test clock.
// - Controller makes capture, shift and update controls for all registers.
// - All sixteen standard controller states exist, none added or omitted.
// - Three-bit instruction: extest, sample, tristate, continuity, bypass codes.
// - One-bit bypass stage sits between data in and out when selected.
// - Power-up resets the test logic and selects bypass.
// - Tristate instruction floats all bus and serial ROM pads.
module boundary_scan_test_port
    import bscan_pkg::*;
(
    // System clock and reset
    input  wire logic   CLK,
    input  wire logic   RESET,
    // Test port
    input  wire logic   TCK,
    input  wire logic   TMS,
    input  wire logic   TDI,
    output logic        TDO,
    output logic        TDO_OE,
    // Core side values and enables
    input  wire chain_t CORE_OUT,
    // Pad side
    input  wire chain_t PAD_IN,
    output chain_t      PAD_OUT,
    output chain_t      PAD_OE
);

    // ==========================================================
    // Test clock domain signals
    tap_state_t         state;
    instr_t             instr_shift;
    instr_t             instruction_register;
    logic               bypass_bit;
    chain_t             chain_shift;
    chain_t             chain_update;
    chain_t             chain_shadow;
    chain_t             pad_meta;
    chain_t             pad_sync;
    chain_t             core_meta;
    chain_t             core_sync;
    chain_t             capture_value;
    logic               extest_tck;
    logic               tristate_tck;
    logic               dirty;
    logic               next_dirty;
    logic               request;
    logic               ack_meta;
    logic               ack_sync;

    // System clock domain signals
    logic               extest_meta;
    logic               extest_clk;
    logic               tristate_meta;
    logic               tristate_clk;
    logic               request_meta;
    logic               request_sync;
    logic               acknowledge;
    chain_t             chain_clk;
    chain_t             next_pad_out;
    chain_t             next_pad_oe;

    // ==========================================================
    // Controller
    tap_state_machine u_tap (
        .tck   (TCK),
        .reset (RESET),
        .tms   (TMS),
        .state (state)
    );

    // ==========================================================
    // Control dispatch
    wire in_reset      = (state == TEST_LOGIC_RESET);
    wire capture_dr    = (state == CAPTURE_DR);
    wire shift_dr      = (state == SHIFT_DR);
    wire update_dr     = (state == UPDATE_DR);
    wire capture_ir    = (state == CAPTURE_IR);
    wire shift_ir      = (state == SHIFT_IR);
    wire update_ir     = (state == UPDATE_IR);

    // Instruction decode
    wire is_extest     = (instruction_register == INSTR_EXTEST);
    wire is_sample     = (instruction_register == INSTR_SAMPLE);
    wire is_tristate   = (instruction_register == INSTR_TRISTATE);
    wire chain_sel     = is_extest | is_sample;
    wire update_chain  = update_dr & chain_sel;
    wire xfer_idle     = (request == ack_sync);
    wire launch        = xfer_idle & dirty;
    wire serial_out    = shift_ir ? instr_shift[0]
                       : (chain_sel ? chain_shift[0] : bypass_bit);

    // ==========================================================
    // Instruction register
    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            instr_shift <= INSTR_RESET;
        end else if (capture_ir) begin
            instr_shift <= INSTR_CAPTURE;
        end else if (shift_ir) begin
            instr_shift <= {TDI, instr_shift[INSTR_LEN-1:1]};
        end
    end

    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            instruction_register <= INSTR_RESET;
        end else if (in_reset) begin
            instruction_register <= INSTR_RESET;
        end else if (update_ir) begin
            instruction_register <= instr_shift;
        end
    end

    // Mode flags held for the system domain
    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            extest_tck   <= BIT_RESET;
            tristate_tck <= BIT_RESET;
        end else begin
            extest_tck   <= is_extest;
            tristate_tck <= is_tristate;
        end
    end

    // ==========================================================
    // Bypass stage
    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            bypass_bit <= BIT_RESET;
        end else if (capture_dr) begin
            bypass_bit <= BIT_RESET;
        end else if (shift_dr) begin
            bypass_bit <= TDI;
        end
    end

    // ==========================================================
    // Pad and core observation into the test clock domain
    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            pad_meta  <= CHAIN_RESET;
            pad_sync  <= CHAIN_RESET;
            core_meta <= CHAIN_RESET;
            core_sync <= CHAIN_RESET;
        end else begin
            pad_meta  <= PAD_IN;
            pad_sync  <= pad_meta;
            core_meta <= CORE_OUT;
            core_sync <= core_meta;
        end
    end

    // Capture source of each cell
    for (genvar c = 0; c < CHAIN_LEN; c++) begin : g_capture
        localparam int KIND = cell_oe_source(c);
        if (KIND == CELL_NO_PAD) begin : g_core
            assign capture_value[c] = core_sync[c];
        end else begin : g_pad
            assign capture_value[c] = pad_sync[c];
        end
    end

    // ==========================================================
    // Boundary-scan shift stage, ordered from test data in
    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            chain_shift <= CHAIN_RESET;
        end else if (capture_dr && chain_sel) begin
            chain_shift <= capture_value;
        end else if (shift_dr && chain_sel) begin
            chain_shift <= {TDI, chain_shift[CHAIN_LEN-1:1]};
        end
    end

    // Boundary-scan update stage
    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            chain_update <= CHAIN_RESET;
        end else if (update_chain) begin
            chain_update <= chain_shift;
        end
    end

    // ==========================================================
    // Handshake of the update word to the system domain
    assign next_dirty = update_chain | (dirty & ~launch);

    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            dirty <= BIT_RESET;
        end else begin
            dirty <= next_dirty;
        end
    end

    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            chain_shadow <= CHAIN_RESET;
            request      <= BIT_RESET;
        end else if (launch) begin
            chain_shadow <= chain_update;
            request      <= ~request;
        end
    end

    always_ff @(posedge TCK or posedge RESET) begin
        if (RESET) begin
            ack_meta <= BIT_RESET;
            ack_sync <= BIT_RESET;
        end else begin
            ack_meta <= acknowledge;
            ack_sync <= ack_meta;
        end
    end

    // ==========================================================
    // Serial output on the falling test clock edge
    always_ff @(negedge TCK or posedge RESET) begin
        if (RESET) begin
            TDO    <= TDO_RESET;
            TDO_OE <= BIT_RESET;
        end else begin
            TDO    <= serial_out;
            TDO_OE <= shift_dr | shift_ir;
        end
    end

    // ==========================================================
    // System domain: mode and word reception
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            extest_meta   <= BIT_RESET;
            extest_clk    <= BIT_RESET;
            tristate_meta <= BIT_RESET;
            tristate_clk  <= BIT_RESET;
        end else begin
            extest_meta   <= extest_tck;
            extest_clk    <= extest_meta;
            tristate_meta <= tristate_tck;
            tristate_clk  <= tristate_meta;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            request_meta <= BIT_RESET;
            request_sync <= BIT_RESET;
        end else begin
            request_meta <= request;
            request_sync <= request_meta;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            chain_clk   <= CHAIN_RESET;
            acknowledge <= BIT_RESET;
        end else if (request_sync != acknowledge) begin
            chain_clk   <= chain_shadow;
            acknowledge <= request_sync;
        end
    end

    // ==========================================================
    // Pad muxing
    for (genvar p = 0; p < CHAIN_LEN; p++) begin : g_pad_mux
        localparam int SRC = cell_oe_source(p);
        wire value = extest_clk ? chain_clk[p] : CORE_OUT[p];
        wire enable;
        if (SRC >= 0) begin : g_group
            assign enable = extest_clk ? chain_clk[SRC] : CORE_OUT[SRC];
        end else if (SRC == CELL_DRIVEN) begin : g_driven
            assign enable = 1'b1;
        end else if (SRC == CELL_OPEN_DRAIN) begin : g_open_drain
            assign enable = ~value;
        end else begin : g_none
            assign enable = 1'b0;
        end
        assign next_pad_out[p] = value;
        assign next_pad_oe[p]  = enable & ~tristate_clk;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PAD_OUT <= CHAIN_RESET;
            PAD_OE  <= CHAIN_RESET;
        end else begin
            PAD_OUT <= next_pad_out;
            PAD_OE  <= next_pad_oe;
        end
    end

endmodule : boundary_scan_test_port

//--- bscan_pkg.sv
// Constants, types and cell map of the boundary-scan test port
package bscan_pkg;

    // ==========================================================
    // Sizes
    localparam int CHAIN_LEN      = 75;
    localparam int INSTR_LEN      = 3;
    localparam int INTERNAL_CELLS = 11;

    // ==========================================================
    // Instruction codes
    typedef logic [INSTR_LEN-1:0] instr_t;
    localparam instr_t INSTR_EXTEST     = 3'h0;
    localparam instr_t INSTR_SAMPLE     = 3'h1;
    localparam instr_t INSTR_TRISTATE   = 3'h5;
    localparam instr_t INSTR_CONTINUITY = 3'h6;
    localparam instr_t INSTR_BYPASS     = 3'h7;
    localparam instr_t INSTR_CAPTURE    = 3'h1;
    localparam instr_t INSTR_RESET      = INSTR_BYPASS;

    // ==========================================================
    // Test access port states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET = 4'h0,
        RUN_TEST_IDLE    = 4'h1,
        SELECT_DR        = 4'h3,
        CAPTURE_DR       = 4'h2,
        SHIFT_DR         = 4'h6,
        EXIT1_DR         = 4'h7,
        PAUSE_DR         = 4'h5,
        EXIT2_DR         = 4'h4,
        UPDATE_DR        = 4'hC,
        SELECT_IR        = 4'hD,
        CAPTURE_IR       = 4'hF,
        SHIFT_IR         = 4'hE,
        EXIT1_IR         = 4'hA,
        PAUSE_IR         = 4'hB,
        EXIT2_IR         = 4'h9,
        UPDATE_IR        = 4'h8
    } tap_state_t;

    // ==========================================================
    // Chain image, first field next to test data in
    typedef struct packed {
        logic                      irq_n;
        logic                      sys_reset_n;
        logic                      bus_clock;
        logic                      grant_n;
        logic                      request_n;
        logic                      ad_enable;
        logic [7:0]                ad_31_24;
        logic                      cbe_enable;
        logic                      cbe_3;
        logic                      idsel;
        logic [7:0]                ad_23_16;
        logic                      cbe_2;
        logic                      frame_enable;
        logic                      frame_n;
        logic                      irdy_enable;
        logic                      irdy_n;
        logic                      trdy_enable;
        logic                      trdy_n;
        logic                      devsel_enable;
        logic                      devsel_n;
        logic                      stop_enable;
        logic                      stop_n;
        logic                      perr_enable;
        logic                      perr_n;
        logic                      serr_n;
        logic                      par_enable;
        logic                      parity;
        logic                      cbe_1;
        logic [7:0]                ad_15_8;
        logic                      cbe_0;
        logic [7:0]                ad_7_0;
        logic                      serial_rom_data_out;
        logic                      serial_rom_data_in;
        logic                      serial_rom_clock;
        logic [INTERNAL_CELLS-1:0] internal_sequencing_cell;
        logic                      boot_rom_address_0;
        logic                      boot_rom_address_1;
    } chain_t;

    // ==========================================================
    // Cell positions in the flat chain, bit 0 next to test data out
    localparam int POS_IRQ            = 74;
    localparam int POS_REQUEST        = 70;
    localparam int POS_AD_ENABLE      = 69;
    localparam int POS_AD_31_24_LO    = 61;
    localparam int POS_CBE_ENABLE     = 60;
    localparam int POS_CBE_3          = 59;
    localparam int POS_AD_23_16_LO    = 50;
    localparam int POS_CBE_2          = 49;
    localparam int POS_FRAME_ENABLE   = 48;
    localparam int POS_PERR           = 37;
    localparam int POS_SERR           = 36;
    localparam int POS_PAR_ENABLE     = 35;
    localparam int POS_PARITY         = 34;
    localparam int POS_CBE_1          = 33;
    localparam int POS_AD_15_8_LO     = 25;
    localparam int POS_CBE_0          = 24;
    localparam int POS_AD_7_0_LO      = 16;
    localparam int POS_SERIAL_ROM_OUT = 15;
    localparam int POS_SERIAL_ROM_CLK = 13;
    localparam int POS_INTERNAL_HI    = 12;
    localparam int POS_INTERNAL_LO    = 2;
    localparam int POS_BOOT_ROM_0     = 1;
    localparam int POS_BOOT_ROM_1     = 0;
    localparam int AD_BYTE_LAST       = 7;

    // Cell kinds; a value of zero or more names the enable cell
    localparam int CELL_INPUT      = -1;
    localparam int CELL_DRIVEN     = -2;
    localparam int CELL_OPEN_DRAIN = -3;
    localparam int CELL_NO_PAD     = -4;

    // ==========================================================
    // Reset values
    localparam chain_t CHAIN_RESET = '0;
    localparam logic   TDO_RESET   = 1'b0;
    localparam logic   BIT_RESET   = 1'b0;

    // ==========================================================
    // Driver of each cell's pad enable
    function automatic bit in_ad_byte(input int i, input int lo);
        return (i >= lo) && (i <= lo + AD_BYTE_LAST);
    endfunction : in_ad_byte

    function automatic int cell_oe_source(input int i);
        int src;
        src = CELL_INPUT;
        if (i >= POS_INTERNAL_LO && i <= POS_INTERNAL_HI) begin
            src = CELL_NO_PAD;
        end else if (i == POS_AD_ENABLE || i == POS_CBE_ENABLE || i == POS_PAR_ENABLE) begin
            src = CELL_NO_PAD;
        end else if (i >= POS_PERR && i <= POS_FRAME_ENABLE) begin
            src = ((i - POS_PERR) % 2 == 1) ? CELL_NO_PAD : i + 1;
        end else if (in_ad_byte(i, POS_AD_31_24_LO) || in_ad_byte(i, POS_AD_23_16_LO)
                     || in_ad_byte(i, POS_AD_15_8_LO) || in_ad_byte(i, POS_AD_7_0_LO)) begin
            src = POS_AD_ENABLE;
        end else if (i == POS_CBE_3 || i == POS_CBE_2 || i == POS_CBE_1 || i == POS_CBE_0) begin
            src = POS_CBE_ENABLE;
        end else if (i == POS_PARITY) begin
            src = POS_PAR_ENABLE;
        end else if (i == POS_IRQ || i == POS_SERR) begin
            src = CELL_OPEN_DRAIN;
        end else if (i == POS_REQUEST || i == POS_SERIAL_ROM_OUT || i == POS_SERIAL_ROM_CLK
                     || i == POS_BOOT_ROM_0 || i == POS_BOOT_ROM_1) begin
            src = CELL_DRIVEN;
        end
        return src;
    endfunction : cell_oe_source

endpackage : bscan_pkg

//--- tap_state_machine.sv
// Sixteen-state test access port controller
`timescale 1ns/1ps
module tap_state_machine
    import bscan_pkg::*;
(
    // Test clock and reset
    input  wire logic       tck,
    input  wire logic       reset,
    // Mode select
    input  wire logic       tms,
    // Current state
    output tap_state_t      state
);

    tap_state_t next_state;

    // ==========================================================
    // Next state
    always_comb begin
        case (state)
            TEST_LOGIC_RESET: next_state = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE:    next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR:        next_state = tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR:       next_state = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:         next_state = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:         next_state = tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:         next_state = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:         next_state = tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:        next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR:        next_state = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR:       next_state = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:         next_state = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:         next_state = tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:         next_state = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:         next_state = tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:        next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            default:          next_state = TEST_LOGIC_RESET;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge tck or posedge reset) begin
        if (reset) begin
            state <= TEST_LOGIC_RESET;
        end else begin
            state <= next_state;
        end
    end

endmodule : tap_state_machine

//--- boundary_scan_test_port_assertions.sv
// Concurrent checks on the boundary-scan test port
`timescale 1ns/1ps
module boundary_scan_test_port_assertions
    import bscan_pkg::*;
(
    // Clocks and reset
    input wire logic   CLK,
    input wire logic   RESET,
    input wire logic   TCK,
    // Test port
    input wire logic   TMS,
    input wire logic   TDO,
    input wire logic   TDO_OE,
    // Pads
    input wire chain_t PAD_OUT,
    input wire chain_t PAD_OE
);
    // ==========================================================
    // Pad side
    a_release_quiet: assert property (@(posedge CLK) disable iff (RESET)
        $fell(RESET) |-> PAD_OE == '0 && PAD_OUT == '0)
        else $error("pads active at reset release");
    a_enable_cells_silent: assert property (@(posedge CLK) disable iff (RESET)
        {PAD_OE.ad_enable, PAD_OE.cbe_enable, PAD_OE.par_enable, PAD_OE.frame_enable} == 4'h0)
        else $error("enable cell drives a pad");
    a_internal_no_pad: assert property (@(posedge CLK) disable iff (RESET)
        PAD_OE.internal_sequencing_cell == '0)
        else $error("internal cell drives a pad");
    a_open_drain_low: assert property (@(posedge CLK) disable iff (RESET)
        PAD_OE.irq_n || PAD_OE.serr_n |-> !(PAD_OE.irq_n && PAD_OUT.irq_n)
            && !(PAD_OE.serr_n && PAD_OUT.serr_n))
        else $error("open-drain pad driven high");
    a_input_pads_free: assert property (@(posedge CLK) disable iff (RESET)
        {PAD_OE.sys_reset_n, PAD_OE.bus_clock, PAD_OE.grant_n, PAD_OE.idsel} == 4'h0)
        else $error("input pad driven");
    // ==========================================================
    // Test clock side
    a_reset_sequence: assert property (@(posedge TCK) disable iff (RESET)
        TMS[*5] |=> !TDO_OE)
        else $error("five mode ones leave a shift state");
    a_ir_capture: assert property (@(posedge TCK) disable iff (RESET)
        TMS[*5] ##1 !TMS ##1 TMS[*2] ##1 !TMS[*2] |=> TDO_OE && TDO)
        else $error("instruction capture not 001");
    a_bypass_capture: assert property (@(posedge TCK) disable iff (RESET)
        TMS[*5] ##1 !TMS ##1 TMS ##1 !TMS[*2] |=> TDO_OE && !TDO)
        else $error("bypass capture not 0");
    a_shift_follow: assert property (@(posedge TCK) disable iff (RESET)
        TDO_OE |=> TDO_OE == !$past(TMS))
        else $error("shift state does not follow mode select");
endmodule : boundary_scan_test_port_assertions

bind boundary_scan_test_port boundary_scan_test_port_assertions u_chk (
    .CLK, .RESET, .TCK, .TMS, .TDO, .TDO_OE, .PAD_OUT, .PAD_OE);

//--- tap_tester_model.sv
// Board tester model driving the test access port
`timescale 1ns/1ps
module tap_tester_model (
    // Test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One test clock period; clock rests low outside frames
    task automatic step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        #24 tck <= 1'b1;
        o = tdo;
        #24 tck <= 1'b0;
    endtask : step
    // Mode sequence, first bit first; data line toggles while unused
    task automatic move(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(seq[i], tdi !== 1'b1, o);
        end
    endtask : move
    // Shift a whole unit, then update and return to idle
    task automatic shift(input logic d[$], output logic q[$]);
        logic o;
        q = {};
        foreach (d[i]) begin
            step(i == d.size() - 1, d[i], o);
            q.push_back(o);
        end
        move(8'h01, 2);
    endtask : shift
    task automatic load_ir(input logic [2:0] c, output logic q[$]);
        move(8'h03, 4);
        shift({c[0], c[1], c[2]}, q);
    endtask : load_ir
    task automatic shift_dr(input logic d[$], output logic q[$]);
        move(8'h01, 3);
        shift(d, q);
    endtask : shift_dr
endmodule : tap_tester_model

//--- tb_boundary_scan_test_port.sv
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
module tb_boundary_scan_test_port;
    import bscan_pkg::*;
    logic        CLK, RESET, TCK, TMS, TDI, TDO, TDO_OE;
    chain_t      CORE_OUT, PAD_IN, PAD_OUT, PAD_OE, w;
    int          errors, checked, cycles;
    integer      seed;
    logic        din[$], dout[$], exp[$];
    logic [74:0] word;
    logic [2:0]  codes[5] = '{INSTR_BYPASS, INSTR_CONTINUITY, 3'h2, 3'h3, 3'h4};

    boundary_scan_test_port dut (.CLK, .RESET, .TCK, .TMS, .TDI, .TDO, .TDO_OE,
        .CORE_OUT, .PAD_IN, .PAD_OUT, .PAD_OE);
    tap_tester_model tester (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            results();
        end
    end
    // ==========================================================
    // Helpers
    task automatic check(input logic [74:0] seen, input logic [74:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    function automatic logic [74:0] pack(input logic q[$]);
        logic [74:0] r;
        r = '0;
        foreach (q[i]) begin
            r[i] = q[i];
        end
        return r;
    endfunction : pack
    function automatic logic [74:0] rnd();
        logic [95:0] r;
        r = {$random(seed), $random(seed), $random(seed)};
        return r[74:0];
    endfunction : rnd
    task automatic fill(input int n);
        din = {};
        repeat (n) din.push_back(1'($random(seed)));
    endtask : fill
    task automatic results();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // ==========================================================
    // Scenarios
    initial begin
        seed = 32'h7382AE9F;
        RESET = 1'b1;
        CORE_OUT = '0;
        PAD_IN = '0;
        fork
            repeat (2) @(posedge CLK);
            tester.move(8'h03, 2);
        join
        @(posedge CLK) RESET <= 1'b0;
        tester.move(8'h00, 1);
        repeat (4) begin
            @(posedge CLK) CORE_OUT <= rnd();
            repeat (2) @(posedge CLK);
            #1 check(75'({PAD_OUT.request_n, PAD_OE.request_n, PAD_OE.irq_n, PAD_OE.ad_7_0}),
                75'({CORE_OUT.request_n, 1'b1, ~CORE_OUT.irq_n, {8{CORE_OUT.ad_enable}}}));
        end
        foreach (codes[i]) begin
            tester.move(8'h1F, 6);
            tester.load_ir(codes[i], dout);
            check(pack(dout), 75'h1);
            fill(8);
            exp = {1'b0, din[0:6]};
            tester.shift_dr(din, dout);
            check(pack(dout), pack(exp));
        end
        @(posedge CLK) PAD_IN <= rnd();
        tester.load_ir(INSTR_SAMPLE, dout);
        fill(83);
        tester.shift_dr(din, dout);
        word = pack(dout[0:74]);
        check(75'(word[POS_AD_31_24_LO +: 8]), 75'(PAD_IN.ad_31_24));
        check(75'(word[POS_AD_7_0_LO +: 8]), 75'(PAD_IN.ad_7_0));
        check(75'(word[POS_INTERNAL_LO +: 11]), 75'(CORE_OUT.internal_sequencing_cell));
        check(pack(dout[75:82]), pack(din[0:7]));
        w = rnd();
        w.ad_enable = 1'b1;
        din = {};
        for (int k = 0; k < 75; k++) begin
            din.push_back(w[k]);
        end
        tester.shift_dr(din, dout);
        tester.load_ir(INSTR_EXTEST, dout);
        tester.move(8'h00, 4);
        repeat (6) @(posedge CLK);
        #1 check(75'({PAD_OUT.ad_31_24, PAD_OE.ad_31_24}), 75'({w.ad_31_24, 8'hFF}));
        tester.load_ir(INSTR_TRISTATE, dout);
        tester.move(8'h00, 4);
        repeat (6) @(posedge CLK);
        #1 check(PAD_OE, '0);
        tester.move(8'h1F, 6);
        fill(8);
        exp = {1'b0, din[0:6]};
        tester.shift_dr(din, dout);
        check(pack(dout), pack(exp));
        check(75'(PAD_OE.request_n), 75'h1);
        results();
    end
endmodule : tb_boundary_scan_test_port
